// *** rtl/mss_pkg.sv ***
// Constants, register map and types of the motor starter contactor sequencer.
// Assumes a 100 MHz ref_clk and an AXI4-Lite master with 32-bit data.
package mss_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MS_NS = 1000000;
	localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
	localparam logic [16:0] ONE_SEC_MS = 17'h003E8;
	localparam logic [16:0] GAP_MS = 17'h00014;
	localparam logic [16:0] MS_PER_SEC = 17'h003E8;
	localparam logic [21:0] HOUR_MS = 22'h36EE80;
	localparam logic [10:0] OCC_LIMIT_MS = 11'h3E8;
	localparam logic [10:0] WELD_LIMIT_MS = 11'h3E9;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DELAY = 8'h04;
	localparam logic [7:0] ADDR_RAMP = 8'h08;
	localparam logic [7:0] ADDR_STARTS = 8'h0C;
	localparam logic [7:0] ADDR_CMD = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_ALARM = 8'h18;

	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_INHIBIT_BIT = 2;
	localparam int unsigned CTRL_ORDER_BIT = 3;
	localparam int unsigned RAMP_DOWN_LSB = 8;
	localparam int unsigned CMD_START_A_BIT = 0;
	localparam int unsigned CMD_START_B_BIT = 1;
	localparam int unsigned CMD_STOP_BIT = 2;

	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [6:0] SECS_RST = 7'h01;
	localparam logic [5:0] STARTS_RST = 6'h28;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_TWO_SPEED,
		MODE_SLIP_RING,
		MODE_INVERTER,
		MODE_AUTOTRANSFORMER
	} mss_mode_t;

	typedef enum logic [3:0] {
		ST_STOP, ST_LOW, ST_L2H, ST_HIGH, ST_XFER,
		ST_SR_A, ST_SR_AB,
		ST_INV_A, ST_INV_UP, ST_INV_RUN, ST_INV_DOWN,
		ST_AT_FIRST, ST_AT_BOTH, ST_AT_GAP, ST_AT_RUN
	} mss_state_t;
endpackage

// *** rtl/mss_sequencer.sv ***
// Contactor sequencer for two-speed, slip-ring, inverter and autotransformer starters.
// Assumes all pins synchronous to ref_clk and an AXI4-Lite master on the register port.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module mss_sequencer #(
	parameter int unsigned MS_CYCLES = mss_pkg::MS_CYCLES_DEF
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sw_start_a,
	input wire logic sw_start_b,
	input wire logic sw_stop,
	input wire logic panel_start_a,
	input wire logic panel_start_b,
	input wire logic panel_stop,
	input wire logic trip_req,
	input wire logic status_a,
	input wire logic status_b,
	input wire logic status_aux,
	output logic contactor_a,
	output logic contactor_b,
	output logic aux_out,
	output logic open_circuit_alarm,
	output logic stuck_closed_alarm,
	output logic drive_no_speed_alarm,
	output logic drive_no_halt_alarm
);
	import mss_pkg::*;

	if (MS_CYCLES < 2) begin : g_bad_ms
		$error("MS_CYCLES must be at least 2.");
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Register bus.
	logic [3:0] ctrl_ff;
	logic [6:0] delay_ff, ramp_up_ff, ramp_down_ff;
	logic [5:0] starts_lim_ff;
	logic [2:0] cmd_ff;
	logic [3:0] alarm_clr_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic aw_ok_ff, w_ok_ff, bvalid_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic wr_go;
	logic [3:0] alarm_ff;
	mss_state_t state_ff, nxt_state;
	logic cont_a_ff, cont_b_ff, aux_ff;

	assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
	assign s_axi_wready = !w_ok_ff && !bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign wr_go = aw_ok_ff && w_ok_ff && !bvalid_ff;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			aw_ok_ff <= 1'b0;
			w_ok_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_ok_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (wr_go) begin
				w_ok_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (awaddr_ff == ADDR_STATUS || awaddr_ff > ADDR_ALARM || awaddr_ff[1:0] != 2'h0) ?
				RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctrl_ff <= CTRL_RST;
			delay_ff <= SECS_RST;
			ramp_up_ff <= SECS_RST;
			ramp_down_ff <= SECS_RST;
			starts_lim_ff <= STARTS_RST;
			cmd_ff <= 3'h0;
			alarm_clr_ff <= 4'h0;
		end else begin
			cmd_ff <= 3'h0;
			alarm_clr_ff <= 4'h0;
			if (wr_go && wstrb_ff[0]) begin
				unique case (awaddr_ff)
					ADDR_CTRL: ctrl_ff <= wdata_ff[3:0];
					ADDR_DELAY: delay_ff <= wdata_ff[6:0];
					ADDR_RAMP: ramp_up_ff <= wdata_ff[6:0];
					ADDR_STARTS: starts_lim_ff <= wdata_ff[5:0];
					ADDR_CMD: cmd_ff <= wdata_ff[2:0];
					ADDR_ALARM: alarm_clr_ff <= wdata_ff[3:0];
					default: ;
				endcase
			end
			if (wr_go && wstrb_ff[1] && awaddr_ff == ADDR_RAMP) begin
				ramp_down_ff <= wdata_ff[RAMP_DOWN_LSB +: 7];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_CTRL: rdata_ff <= {28'h0000000, ctrl_ff};
				ADDR_DELAY: rdata_ff <= {25'h0000000, delay_ff};
				ADDR_RAMP: rdata_ff <= {17'h00000, ramp_down_ff, 1'b0, ramp_up_ff};
				ADDR_STARTS: rdata_ff <= {26'h0000000, starts_lim_ff};
				ADDR_CMD: rdata_ff <= 32'h00000000;
				ADDR_STATUS: rdata_ff <= {21'h000000, state_ff, status_aux, status_b, status_a,
					aux_ff, cont_b_ff, cont_a_ff, 1'b0};
				ADDR_ALARM: rdata_ff <= {28'h0000000, alarm_ff};
				default: begin
					rdata_ff <= 32'h00000000;
					rresp_ff <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Millisecond tick and hour window.
	logic [$clog2(MS_CYCLES)-1:0] tick_cnt_ff;
	logic tick;
	logic [21:0] hour_ms_ff;
	logic [5:0] starts_ff;

	assign tick = (tick_cnt_ff == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Commands and configuration decode.
	mss_mode_t mode;
	logic cmd_a, cmd_b, cmd_stop, inhibit, wye_coil_first, start_ok, at_start;

	assign mode = mss_mode_t'(ctrl_ff[CTRL_MODE_LSB +: 2]);
	assign inhibit = ctrl_ff[CTRL_INHIBIT_BIT];
	assign wye_coil_first = !ctrl_ff[CTRL_ORDER_BIT];
	assign cmd_a = cmd_ff[CMD_START_A_BIT] | sw_start_a | panel_start_a;
	assign cmd_b = cmd_ff[CMD_START_B_BIT] | sw_start_b | panel_start_b;
	assign cmd_stop = cmd_ff[CMD_STOP_BIT] | sw_stop | panel_stop | trip_req;
	assign start_ok = starts_ff < starts_lim_ff;
	assign at_start = state_ff == ST_STOP && nxt_state == ST_AT_FIRST;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			hour_ms_ff <= 22'h000000;
			starts_ff <= 6'h00;
		end else begin
			if (tick && hour_ms_ff == HOUR_MS - 22'h000001) begin
				hour_ms_ff <= 22'h000000;
				starts_ff <= 6'h00;
			end else begin
				if (tick) begin
					hour_ms_ff <= hour_ms_ff + 22'h000001;
				end
				if (at_start) begin
					starts_ff <= starts_ff + 6'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Contactor feedback supervision, one timer pair per output.
	logic [2:0] outs, stats, occ_mask, weld_mask, occ_hit, weld_hit;
	logic occ_evt, weld_evt;

	assign outs = {aux_ff, cont_b_ff, cont_a_ff};
	assign stats = {status_aux, status_b, status_a};
	assign occ_mask = (mode == MODE_INVERTER) ? 3'h1 : (mode == MODE_AUTOTRANSFORMER) ? 3'h7 : 3'h3;
	assign weld_mask = occ_mask;

	for (genvar i = 0; i < 3; i++) begin : g_sup
		logic [10:0] occ_ms_ff, weld_ms_ff;
		always_ff @(posedge ref_clk) begin
			if (!rstn) begin
				occ_ms_ff <= 11'h000;
				weld_ms_ff <= 11'h000;
			end else begin
				if (!outs[i] || stats[i] || occ_hit[i]) begin
					occ_ms_ff <= 11'h000;
				end else if (tick) begin
					occ_ms_ff <= occ_ms_ff + 11'h001;
				end
				if (outs[i] || !stats[i] || weld_hit[i]) begin
					weld_ms_ff <= 11'h000;
				end else if (tick) begin
					weld_ms_ff <= weld_ms_ff + 11'h001;
				end
			end
		end
		assign occ_hit[i] = occ_mask[i] && occ_ms_ff >= OCC_LIMIT_MS;
		assign weld_hit[i] = weld_mask[i] && weld_ms_ff >= WELD_LIMIT_MS;
	end
	assign occ_evt = |occ_hit;
	assign weld_evt = |weld_hit;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Sequencer.
	logic [16:0] seq_ms_ff, delay_ms, up_ms, down_ms, chg_ms;
	logic set_no_speed, set_no_halt;

	assign delay_ms = 17'(delay_ff * MS_PER_SEC);
	assign up_ms = 17'(ramp_up_ff * MS_PER_SEC);
	assign down_ms = 17'(ramp_down_ff * MS_PER_SEC);
	assign chg_ms = wye_coil_first ? delay_ms - GAP_MS : delay_ms;

	always_comb begin
		nxt_state = state_ff;
		set_no_speed = 1'b0;
		set_no_halt = 1'b0;
		unique case (state_ff)
			ST_STOP: begin
				if (!cmd_stop && (cmd_a || cmd_b)) begin
					unique case (mode)
						MODE_TWO_SPEED: nxt_state = cmd_a ? ST_LOW : (inhibit ? ST_STOP : ST_HIGH);
						MODE_SLIP_RING: nxt_state = ST_SR_A;
						MODE_INVERTER: nxt_state = ST_INV_A;
						MODE_AUTOTRANSFORMER: nxt_state = start_ok ? ST_AT_FIRST : ST_STOP;
					endcase
				end
			end
			ST_LOW: if (cmd_stop) nxt_state = ST_STOP; else if (cmd_b) nxt_state = ST_L2H;
			ST_L2H: nxt_state = cmd_stop ? ST_STOP : ST_HIGH;
			ST_HIGH: if (cmd_stop) nxt_state = ST_STOP; else if (cmd_a) nxt_state = ST_XFER;
			ST_XFER: if (cmd_stop) nxt_state = ST_STOP; else if (seq_ms_ff >= delay_ms) nxt_state = ST_LOW;
			ST_SR_A: if (cmd_stop) nxt_state = ST_STOP; else if (seq_ms_ff >= delay_ms) nxt_state = ST_SR_AB;
			ST_SR_AB: if (cmd_stop) nxt_state = ST_STOP;
			ST_INV_A: if (cmd_stop) nxt_state = ST_INV_DOWN; else if (seq_ms_ff >= ONE_SEC_MS) nxt_state = ST_INV_UP;
			ST_INV_UP: begin
				if (cmd_stop) begin
					nxt_state = ST_INV_DOWN;
				end else if (status_b) begin
					nxt_state = ST_INV_RUN;
				end else if (seq_ms_ff >= up_ms) begin
					set_no_speed = 1'b1;
					nxt_state = ST_INV_RUN;
				end
			end
			ST_INV_RUN: if (cmd_stop) nxt_state = ST_INV_DOWN;
			ST_INV_DOWN: begin
				if (!status_b) begin
					nxt_state = ST_STOP;
				end else if (seq_ms_ff >= down_ms) begin
					set_no_halt = 1'b1;
				end
			end
			ST_AT_FIRST: if (cmd_stop) nxt_state = ST_STOP; else if (seq_ms_ff >= GAP_MS) nxt_state = ST_AT_BOTH;
			ST_AT_BOTH: if (cmd_stop) nxt_state = ST_STOP; else if (seq_ms_ff >= chg_ms) nxt_state = ST_AT_GAP;
			ST_AT_GAP: if (cmd_stop) nxt_state = ST_STOP; else if (seq_ms_ff >= GAP_MS) nxt_state = ST_AT_RUN;
			ST_AT_RUN: if (cmd_stop) nxt_state = ST_STOP;
			default: nxt_state = ST_STOP;
		endcase
		if (occ_evt) begin
			nxt_state = ST_STOP;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_ff <= ST_STOP;
			seq_ms_ff <= 17'h00000;
			cont_a_ff <= 1'b0;
			cont_b_ff <= 1'b0;
			aux_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			seq_ms_ff <= (nxt_state != state_ff) ? 17'h00000 : seq_ms_ff + {16'h0000, tick};
			cont_a_ff <= nxt_state inside {ST_LOW, ST_SR_A, ST_SR_AB, ST_INV_A, ST_INV_UP, ST_INV_RUN,
				ST_INV_DOWN, ST_AT_BOTH} || (nxt_state == ST_AT_FIRST && wye_coil_first);
			cont_b_ff <= nxt_state inside {ST_HIGH, ST_SR_AB, ST_INV_UP, ST_INV_RUN, ST_AT_RUN};
			aux_ff <= nxt_state == ST_AT_BOTH || (nxt_state == ST_AT_FIRST && !wye_coil_first);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			alarm_ff <= 4'h0;
		end else begin
			alarm_ff <= (alarm_ff & ~alarm_clr_ff) | {set_no_halt, set_no_speed, weld_evt, occ_evt};
		end
	end

	assign contactor_a = cont_a_ff;
	assign contactor_b = cont_b_ff;
	assign aux_out = aux_ff;
	assign open_circuit_alarm = alarm_ff[0];
	assign stuck_closed_alarm = alarm_ff[1];
	assign drive_no_speed_alarm = alarm_ff[2];
	assign drive_no_halt_alarm = alarm_ff[3];

	////////////////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence s_all_open;
		!contactor_a && !contactor_b && !aux_out;
	endsequence
	sequence s_gap_then_b;
		!contactor_a && !contactor_b ##1 contactor_b && !contactor_a;
	endsequence

	a_inhibit_ignored: assert property (
		state_ff == ST_STOP && mode == MODE_TWO_SPEED && inhibit && cmd_b && !cmd_a && !occ_evt
		|=> s_all_open and (state_ff == ST_STOP)) else $error("Inhibited start B moved the contactors.");
	a_low_to_high: assert property (
		state_ff == ST_LOW && mode == MODE_TWO_SPEED && cmd_b && !cmd_stop && !occ_evt ##1 !cmd_stop && !occ_evt
		|-> s_gap_then_b) else $error("Low to high transition out of order.");
	a_high_to_low: assert property (
		state_ff == ST_HIGH && cmd_a && !cmd_stop && !occ_evt |=> !contactor_a && !contactor_b)
		else $error("High to low did not open both contactors.");
	a_stop_opens: assert property (
		cmd_stop && state_ff inside {ST_LOW, ST_HIGH, ST_SR_A, ST_SR_AB, ST_AT_RUN} |=> s_all_open)
		else $error("Stop left a contactor closed.");
	a_occ_opens: assert property (
		occ_evt |=> s_all_open and open_circuit_alarm) else $error("Open circuit fault did not open outputs.");
	a_weld_flag: assert property (
		weld_evt |=> stuck_closed_alarm) else $error("Stuck contactor not flagged.");
	a_slip_stage: assert property (
		state_ff == ST_SR_A && !cmd_stop && !occ_evt && seq_ms_ff < delay_ms |=> !contactor_b && contactor_a)
		else $error("Slip-ring B closed before the shorting delay.");
	a_inv_hold_a: assert property (
		state_ff == ST_INV_DOWN && status_b && !occ_evt |=> contactor_a && !contactor_b)
		else $error("Drive power removed before run feedback cleared.");
	a_inv_no_halt: assert property (
		set_no_halt |=> drive_no_halt_alarm) else $error("Drive stop failure not flagged.");
	a_starts_limit: assert property (
		state_ff == ST_STOP && mode == MODE_AUTOTRANSFORMER && !start_ok |=> state_ff == ST_STOP)
		else $error("Start accepted beyond the hourly limit.");
	a_wye_first: assert property (
		$rose(contactor_a) && mode == MODE_AUTOTRANSFORMER && wye_coil_first && state_ff == ST_AT_FIRST
		|-> !aux_out) else $error("Auxiliary closed together with A.");
	a_tick_single: assert property (
		tick |=> !tick) else $error("Millisecond tick longer than one cycle.");
endmodule

// *** sim/mss_contactor_model.sv ***
// Contactor, auxiliary relay and drive feedback model for the sequencer bench.
// Assumes relay drives on ref_clk; the bench sets the mute, stick and slow controls.
`timescale 1ns/10ps
module mss_contactor_model #(
	parameter int LAT = 20
) (
	input wire logic ref_clk,
	input wire logic contactor_a,
	input wire logic contactor_b,
	input wire logic aux_out,
	input wire logic [2:0] mute,
	input wire logic [2:0] stick,
	input wire logic slow,
	output logic status_a,
	output logic status_b,
	output logic status_aux
);
	logic [2:0] rel;
	logic [2:0] st = 3'h0;
	logic [2:0] held = 3'h0;
	int cnt [3] = '{0, 0, 0};
	assign rel = {aux_out, contactor_b, contactor_a};
	// Each contact follows its coil after a pickup time; a stuck contact stays made.
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < 3; i++) begin
			cnt[i] <= (rel[i] == st[i]) ? 0 : cnt[i] + 1;
			if (rel[i] != st[i] && cnt[i] >= (slow ? 10 * LAT : LAT)) begin
				st[i] <= rel[i];
			end
			held[i] <= stick[i] && (held[i] || st[i]);
		end
	end
	assign {status_aux, status_b, status_a} = ~mute & (st | held);
endmodule

// *** sim/tb_mss_sequencer.sv ***
// Self-checking bench for the motor starter contactor sequencer.
// Assumes mss_pkg, the sequencer and the contactor model are compiled first.
`timescale 1ns/10ps
module tb_mss_sequencer;
	import mss_pkg::*;
	localparam int MSC = 4;
	localparam int SEC = 1000 * MSC;
	localparam int T = 3 * MSC;
	logic ref_clk = 1'b0, rstn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic sw_start_a = 1'b0, sw_start_b = 1'b0, sw_stop = 1'b0, trip_req = 1'b0;
	logic panel_start_a = 1'b0, panel_start_b = 1'b0, panel_stop = 1'b0;
	logic status_a, status_b, status_aux, contactor_a, contactor_b, aux_out;
	logic open_circuit_alarm, stuck_closed_alarm, drive_no_speed_alarm, drive_no_halt_alarm;
	logic [2:0] mute = 3'h0, stick = 3'h0;
	logic slow = 1'b0;
	logic [6:0] outs;
	int failures = 0;
	int num_checks = 0;
	assign outs = {drive_no_halt_alarm, drive_no_speed_alarm, stuck_closed_alarm, open_circuit_alarm,
		aux_out, contactor_b, contactor_a};
	mss_sequencer #(.MS_CYCLES(MSC)) mss_sequencer_inst (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .sw_start_a, .sw_start_b, .sw_stop, .panel_start_a, .panel_start_b, .panel_stop,
		.trip_req, .status_a, .status_b, .status_aux, .contactor_a, .contactor_b, .aux_out, .open_circuit_alarm,
		.stuck_closed_alarm, .drive_no_speed_alarm, .drive_no_halt_alarm);
	mss_contactor_model mss_contactor_model_inst (.ref_clk, .contactor_a, .contactor_b, .aux_out, .mute,
		.stick, .slow, .status_a, .status_b, .status_aux);
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_o(input string nm, input logic [6:0] e);
		chk(nm, 32'(e), 32'(outs));
	endtask
	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw;
		bit w;
		aw = 0;
		w = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1 && !aw) begin
				aw = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1 && !w) begin
				w = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge ref_clk);
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge ref_clk);
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk("bresp", 32'(RESP_OKAY), 32'(r));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk(nm, e, d);
		chk("rresp", 32'(RESP_OKAY), 32'(r));
	endtask
	// Source 0 switch, 1 panel, 2 command register, 3 trip; c is {stop, start b, start a}.
	task automatic cmd(input int src, input logic [2:0] c);
		if (src == 2) begin
			wr(ADDR_CMD, 32'(c));
		end else begin
			@(posedge ref_clk);
			case (src)
				0: {sw_stop, sw_start_b, sw_start_a} <= c;
				1: {panel_stop, panel_start_b, panel_start_a} <= c;
				default: trip_req <= c[2];
			endcase
			@(posedge ref_clk);
			{sw_stop, sw_start_b, sw_start_a} <= 3'h0;
			{panel_stop, panel_start_b, panel_start_a} <= 3'h0;
			trip_req <= 1'b0;
		end
	endtask
	task automatic wait_bit(input int b, input logic v, input int lo, input int hi, input string nm);
		int n;
		n = 0;
		while (outs[b] !== v && n <= hi) begin
			@(posedge ref_clk);
			n++;
		end
		num_checks++;
		if (n < lo || n > hi) begin
			failures++;
			$display("CHECK FAILED %s expected %0d to %0d cycles seen %0d", nm, lo, hi, n);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		chk_o("reset outputs", 7'h00);
		rd(ADDR_CTRL, 32'h0, "ctrl");
		rd(ADDR_DELAY, 32'h1, "delay");
		rd(ADDR_RAMP, 32'h101, "ramp");
		rd(ADDR_STARTS, 32'h28, "starts");
		wr(ADDR_RAMP, 32'h00000203);
		rd(ADDR_RAMP, 32'h00000203, "ramp fields");
		wr(ADDR_RAMP, 32'h00000101);
		axi_rd(8'h40, d, r);
		chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
		chk("unmapped data", 32'h0, d);
		axi_wr(ADDR_STATUS, 32'h0, r);
		chk("read only resp", 32'(RESP_SLVERR), 32'(r));
		done("reset");
		for (int s = 0; s < 3; s++) begin
			cmd(s, 3'h1);
			wait_bit(0, 1'b1, 0, 8, "start a");
			cmd(s, 3'h4);
			wait_bit(0, 1'b0, 0, 8, "stop a");
			chk_o("stopped", 7'h00);
		end
		done("sources");
		wr(ADDR_CTRL, 32'h4);
		cmd(0, 3'h2);
		repeat (20) @(posedge ref_clk);
		chk_o("inhibited", 7'h00);
		cmd(1, 3'h1);
		wait_bit(0, 1'b1, 0, 8, "low");
		cmd(2, 3'h2);
		wait_bit(0, 1'b0, 0, 8, "a opens");
		chk_o("a before b", 7'h00);
		wait_bit(1, 1'b1, 0, 3, "high");
		cmd(0, 3'h1);
		wait_bit(1, 1'b0, 0, 8, "b opens");
		wait_bit(0, 1'b1, SEC - T, SEC + T, "transfer");
		chk_o("low again", 7'h01);
		cmd(3, 3'h4);
		wait_bit(0, 1'b0, 0, 8, "trip");
		wr(ADDR_CTRL, 32'h0);
		cmd(0, 3'h2);
		wait_bit(1, 1'b1, 0, 8, "direct high");
		chk_o("only b", 7'h02);
		cmd(0, 3'h4);
		wait_bit(1, 1'b0, 0, 8, "stop b");
		done("two speed");
		mute <= 3'h7;
		cmd(0, 3'h1);
		wait_bit(0, 1'b1, 0, 8, "a closes");
		wait_bit(3, 1'b1, SEC - T, SEC + T, "open circuit");
		repeat (2) @(posedge ref_clk);
		chk_o("all open", 7'h08);
		mute <= 3'h0;
		wr(ADDR_ALARM, 32'hF);
		rd(ADDR_ALARM, 32'h0, "alarm cleared");
		stick <= 3'h1;
		cmd(0, 3'h1);
		wait_bit(0, 1'b1, 0, 8, "a closes");
		repeat (40) @(posedge ref_clk);
		cmd(0, 3'h4);
		wait_bit(0, 1'b0, 0, 8, "a opens");
		wait_bit(4, 1'b1, SEC - T, SEC + T, "stuck");
		stick <= 3'h0;
		repeat (40) @(posedge ref_clk);
		wr(ADDR_ALARM, 32'hF);
		done("supervision");
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_DELAY, 32'h2);
		cmd(1, 3'h1);
		wait_bit(0, 1'b1, 0, 8, "stage one");
		wait_bit(1, 1'b1, 2 * SEC - T, 2 * SEC + T, "shorting");
		chk_o("both", 7'h03);
		rd(ADDR_STATUS, 32'h00000316, "status word");
		cmd(2, 3'h4);
		wait_bit(0, 1'b0, 0, 8, "slip stop");
		chk_o("both open", 7'h00);
		wr(ADDR_DELAY, 32'h1);
		done("slip ring");
		wr(ADDR_CTRL, 32'h2);
		slow <= 1'b1;
		cmd(0, 3'h1);
		wait_bit(0, 1'b1, 0, 8, "drive power");
		wait_bit(1, 1'b1, SEC - T, SEC + T, "drive run");
		repeat (300) @(posedge ref_clk);
		cmd(0, 3'h4);
		wait_bit(1, 1'b0, 0, 8, "run off");
		chk_o("power held", 7'h01);
		wait_bit(0, 1'b0, 180, 230, "power off");
		slow <= 1'b0;
		mute <= 3'h2;
		cmd(0, 3'h1);
		wait_bit(1, 1'b1, SEC - T, SEC + T, "drive run");
		wait_bit(5, 1'b1, SEC - T, SEC + T, "no speed");
		mute <= 3'h0;
		stick <= 3'h2;
		repeat (40) @(posedge ref_clk);
		cmd(0, 3'h4);
		wait_bit(1, 1'b0, 0, 8, "run off");
		wait_bit(6, 1'b1, SEC - T, SEC + T, "no halt");
		chk_o("power kept", 7'h61);
		stick <= 3'h0;
		wait_bit(0, 1'b0, 0, 40, "power off");
		wr(ADDR_ALARM, 32'hF);
		rd(ADDR_ALARM, 32'h0, "alarm cleared");
		done("inverter");
		for (int o = 0; o < 2; o++) begin
			wr(ADDR_CTRL, 32'h3 | 32'(o << 3));
			cmd(0, 3'h1);
			wait_bit(o ? 2 : 0, 1'b1, 0, 8, "first coil");
			chk_o("one coil", o ? 7'h04 : 7'h01);
			wait_bit(o ? 0 : 2, 1'b1, 20 * MSC - T, 20 * MSC + T, "second coil");
			wait_bit(0, 1'b0, (o ? SEC : SEC - 20 * MSC) - T, (o ? SEC : SEC - 20 * MSC) + T, "changeover");
			chk_o("gap", 7'h00);
			wait_bit(1, 1'b1, 20 * MSC - T, 20 * MSC + T, "run coil");
			chk_o("run", 7'h02);
			cmd(0, 3'h4);
			wait_bit(1, 1'b0, 0, 8, "at stop");
		end
		wr(ADDR_STARTS, 32'h2);
		cmd(0, 3'h1);
		repeat (40) @(posedge ref_clk);
		chk_o("start blocked", 7'h00);
		done("autotransformer");
		wr(ADDR_CTRL, 32'h1);
		cmd(0, 3'h1);
		wait_bit(0, 1'b1, 0, 8, "run before reset");
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		chk_o("in reset", 7'h00);
		rstn <= 1'b1;
		rd(ADDR_CTRL, 32'h0, "ctrl after reset");
		rd(ADDR_STARTS, 32'h28, "starts after reset");
		done("second reset");
		complete_run();
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		failures++;
		$display("CHECK FAILED watchdog expected finish seen timeout");
		complete_run();
	end
endmodule
